/* File: fspc_consts.svh */
// Summary of operation
// (RQ1) Software loads address, selects program space, reads
// (RQ2) Second instruction after read start is squashed
// (RQ3) Read word lands next cycle, held
// (RQ4) Software puts two no-ops after read start
// (RQ5) Reads ignore the code-protect setting
// (RQ6) Erase row is 32 aligned words
// (RQ7) Eight aligned write latches per block
// (RQ8) Erase needs selects, enable, unlock, then go
// (RQ9) Erase-select bit clears when erase finishes
// (RQ10) Two squashed setup cycles after program-go
// (RQ11) Erase halts core about 2 ms
// (RQ12) Resume at third instruction after go
// (RQ13) Writing never erases automatically
// (RQ14) Block write stays inside its latch block
// (RQ15) Latches return to all ones after write
// (RQ16) Latch-only go just loads one latch
// (RQ17) Latch-only load never stalls the core
// (RQ18) Final go loads last latch, programs block
// (RQ19) Block write halts only on final step
// (RQ20) Every go needs the 55h/AAh unlock pair
// (RQ21) Software steps address between latch loads
// (RQ22) Latch holds 14-bit word from data pair
// (RQ23) Protected destinations are refused
// (RQ24) Low three address bits pick latch
`ifndef FSPC_CONSTS_SVH
`define FSPC_CONSTS_SVH

// Register byte offsets on the APB
`define FSPC_OFF_ADDR_LO 12'h000
`define FSPC_OFF_ADDR_HI 12'h004
`define FSPC_OFF_DATA_LO 12'h008
`define FSPC_OFF_DATA_HI 12'h00c
`define FSPC_OFF_CTRL 12'h010
`define FSPC_OFF_UNLOCK 12'h014

// Control register bit positions
`define FSPC_BIT_RD 0
`define FSPC_BIT_WR 1
`define FSPC_BIT_PROGRAM_ENABLE 2
`define FSPC_BIT_FREE 3
`define FSPC_BIT_LATCH_ONLY 4
`define FSPC_BIT_CONFIG_SPACE_SELECT 5
`define FSPC_BIT_PGD 6
`define FSPC_BIT_ERR 7
`define FSPC_CTRL_RST 8'h00

// Unlock keys and tracker states
`define FSPC_KEY1 8'h55
`define FSPC_KEY2 8'haa
`define FSPC_UNLK_NONE 2'h0
`define FSPC_UNLK_HALF 2'h1
`define FSPC_UNLK_FULL 2'h2

// Array geometry
`define FSPC_ERASED 14'h3fff
`define FSPC_ROW_MASK 14'h3fe0
`define FSPC_LATCHES 8
`define FSPC_LAST_LATCH 4'h8

// Protection field limits
`define FSPC_PROT_NONE 2'h3
`define FSPC_PROT_LOW 2'h2
`define FSPC_PROT_HALF 2'h1
`define FSPC_LIM_LOW 14'h0200
`define FSPC_LIM_HALF 14'h2000

// Timing
`define FSPC_T_CELL_US 2000
`define FSPC_CLK_MHZ 200
`define FSPC_INSTR_CLKS 4

`endif

/* File: fspc_pkg.sv */
package fspc_pkg;

	// Sequencer states, one-hot
	typedef enum logic [8:0] {
		S_IDLE = 9'h001,
		S_RD_ALIGN = 9'h002,
		S_RD_PASS = 9'h004,
		S_RD_DO = 9'h008,
		S_GO_ALIGN = 9'h010,
		S_SETUP1 = 9'h020,
		S_SETUP2 = 9'h040,
		S_PROG = 9'h080,
		S_BUSY = 9'h100
	} fspc_state_t;

	// Request to the flash array macro
	typedef struct packed {
		logic rd;
		logic erase;
		logic prog;
		logic [13:0] addr;
		logic [13:0] wdata;
	} fspc_flash_req_t;

endpackage

/* File: fspc_latch_mem.sv */
`timescale 1ns/1ps
`include "fspc_consts.svh"

module fspc_latch_mem #(
	parameter int DEPTH = `FSPC_LATCHES,
	parameter int W = 14
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic we,
	input wire logic [$clog2(DEPTH)-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic setAll,
	input wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem_q [DEPTH];
	logic [W-1:0] rdata_q;

	// Bulk preset wins over a load in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) mem_q[i] <= `FSPC_ERASED;
		end else if (setAll) begin
			for (int i = 0; i < DEPTH; i++) mem_q[i] <= `FSPC_ERASED; // RQ15
		end else if (we) begin
			mem_q[waddr] <= wdata;
		end
	end

	// Registered read port
	always_ff @(posedge clk or posedge rst) begin
		if (rst) rdata_q <= `FSPC_ERASED;
		else rdata_q <= mem_q[raddr];
	end

	assign rdata = rdata_q;
endmodule

/* File: fspc_timer.sv */
`timescale 1ns/1ps
`include "fspc_consts.svh"

module fspc_timer #(
	parameter int INSTR_CLKS = `FSPC_INSTR_CLKS,
	parameter int CNT_W = 20
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [CNT_W-1:0] loadVal,
	output logic cycEn,
	output logic done
);
	localparam int DIV_W = $clog2(INSTR_CLKS + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INSTR_CLKS - 1);
	logic [DIV_W-1:0] div_q;
	logic [CNT_W-1:0] cnt_q;

	// Instruction-cycle enable, free running
	assign cycEn = (div_q == DIV_LAST);
	assign done = (cnt_q == CNT_W'(1));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) div_q <= '0;
		else div_q <= cycEn ? '0 : div_q + DIV_W'(1);
	end

	// Cell-time countdown; done pulses on the last count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) cnt_q <= '0;
		else if (start) cnt_q <= loadVal;
		else if (cnt_q != '0) cnt_q <= cnt_q - CNT_W'(1);
	end
endmodule

/* File: fspc_top.sv */
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`include "fspc_consts.svh"

module fspc_top
	import fspc_pkg::*;
#(
	parameter int CELL_CYCLES = `FSPC_T_CELL_US * `FSPC_CLK_MHZ,
	parameter int INSTR_CLKS = `FSPC_INSTR_CLKS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] protectRegion,
	input wire logic [13:0] flashRdData,
	output fspc_flash_req_t flashReq,
	output logic cpuSquash,
	output logic cpuHalt
);
	localparam int CNT_W = $clog2(CELL_CYCLES + 1);
	localparam logic [CNT_W-1:0] CELL_LOAD = CNT_W'(CELL_CYCLES);

	fspc_state_t state_q, state_d;
	logic [7:0] addrLo_q, ctrl_q, ctrl_d;
	logic [5:0] addrHi_q;
	logic [7:0] dataLo_q;
	logic [5:0] dataHi_q;
	logic [1:0] unlk_q;
	logic [13:0] opAddr_q;
	logic opErase_q, opLatch_q;
	logic [3:0] progCnt_q;
	logic [31:0] prdata_q, rdMux;
	fspc_flash_req_t flashReq_q, flashReqD;
	logic cycEn, timerDone, timerStart;
	logic [13:0] latchRd;

	// Protection decode of a destination word
	function automatic logic isProtected(input logic [13:0] a, input logic [1:0] r);
		case (r)
			`FSPC_PROT_NONE: isProtected = 1'b0;
			`FSPC_PROT_LOW: isProtected = (a < `FSPC_LIM_LOW);
			`FSPC_PROT_HALF: isProtected = (a < `FSPC_LIM_HALF);
			default: isProtected = 1'b1;
		endcase
	endfunction

	// APB decode, zero wait states
	wire apbSetup = psel & ~penable;
	wire apbAccess = psel & penable;
	wire hitAddrLo = (paddr == `FSPC_OFF_ADDR_LO);
	wire hitAddrHi = (paddr == `FSPC_OFF_ADDR_HI);
	wire hitDataLo = (paddr == `FSPC_OFF_DATA_LO);
	wire hitDataHi = (paddr == `FSPC_OFF_DATA_HI);
	wire hitCtrl = (paddr == `FSPC_OFF_CTRL);
	wire hitUnlock = (paddr == `FSPC_OFF_UNLOCK);
	wire hitAny = hitAddrLo | hitAddrHi | hitDataLo | hitDataHi | hitCtrl | hitUnlock;
	wire apbWr = apbAccess & pwrite & hitAny;
	assign pready = 1'b1;
	assign pslverr = apbAccess & ~hitAny;
	assign prdata = prdata_q;

	// Read mux; unlock register reads as zero so keys never leak
	always_comb begin
		rdMux = 32'h0;
		if (hitAddrLo) rdMux[7:0] = addrLo_q;
		if (hitAddrHi) rdMux[5:0] = addrHi_q;
		if (hitDataLo) rdMux[7:0] = dataLo_q;
		if (hitDataHi) rdMux[5:0] = dataHi_q;
		if (hitCtrl) rdMux[7:0] = ctrl_q;
	end

	// Read data registered in the setup phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) prdata_q <= 32'h0;
		else if (apbSetup) prdata_q <= rdMux;
	end

	// Request qualification
	wire [13:0] fullAddr = {addrHi_q, addrLo_q};
	wire isIdle = (state_q == S_IDLE);
	wire progSpace = ctrl_q[`FSPC_BIT_PGD] & ~ctrl_q[`FSPC_BIT_CONFIG_SPACE_SELECT];
	wire goReq = isIdle & ctrl_q[`FSPC_BIT_WR];
	wire rdReq = isIdle & ctrl_q[`FSPC_BIT_RD] & ~ctrl_q[`FSPC_BIT_WR];
	// Latch-only loads do not touch the array, so no protection check
	wire goProt = ~ctrl_q[`FSPC_BIT_LATCH_ONLY] & isProtected(fullAddr, protectRegion); // RQ23
	wire goOk = (unlk_q == `FSPC_UNLK_FULL) & ctrl_q[`FSPC_BIT_PROGRAM_ENABLE] & progSpace & ~goProt; // RQ20
	wire goAccept = goReq & goOk;
	wire goRefuse = goReq & ~goOk;
	wire rdAccept = rdReq & progSpace; // RQ5
	wire rdRefuse = rdReq & ~progSpace;
	wire rdDone = (state_q == S_RD_DO) & cycEn;
	wire setupEnd = (state_q == S_SETUP2) & cycEn;
	wire opDone = (state_q == S_BUSY) & timerDone;
	wire latchWe = setupEnd & ~opErase_q; // RQ16 RQ18
	wire progLast = (state_q == S_PROG) & (progCnt_q == `FSPC_LAST_LATCH);
	assign timerStart = (setupEnd & opErase_q) | progLast;

	// Control register: software sets RD/WR only, hardware clears them
	always_comb begin
		ctrl_d = ctrl_q;
		if (apbWr & hitCtrl) begin
			ctrl_d[`FSPC_BIT_PROGRAM_ENABLE] = pwdata[`FSPC_BIT_PROGRAM_ENABLE];
			ctrl_d[`FSPC_BIT_FREE] = pwdata[`FSPC_BIT_FREE];
			ctrl_d[`FSPC_BIT_LATCH_ONLY] = pwdata[`FSPC_BIT_LATCH_ONLY];
			ctrl_d[`FSPC_BIT_CONFIG_SPACE_SELECT] = pwdata[`FSPC_BIT_CONFIG_SPACE_SELECT];
			ctrl_d[`FSPC_BIT_PGD] = pwdata[`FSPC_BIT_PGD];
			ctrl_d[`FSPC_BIT_RD] = ctrl_q[`FSPC_BIT_RD] | (pwdata[`FSPC_BIT_RD] & isIdle);
			ctrl_d[`FSPC_BIT_WR] = ctrl_q[`FSPC_BIT_WR] | (pwdata[`FSPC_BIT_WR] & isIdle);
			ctrl_d[`FSPC_BIT_ERR] = ctrl_q[`FSPC_BIT_ERR] & pwdata[`FSPC_BIT_ERR];
		end
		if (rdDone | rdRefuse) ctrl_d[`FSPC_BIT_RD] = 1'b0;
		if (latchWe & opLatch_q) ctrl_d[`FSPC_BIT_WR] = 1'b0;
		if (opDone) ctrl_d[`FSPC_BIT_WR] = 1'b0;
		if (opDone & opErase_q) ctrl_d[`FSPC_BIT_FREE] = 1'b0; // RQ9
		if (goRefuse) begin
			ctrl_d[`FSPC_BIT_WR] = 1'b0;
			ctrl_d[`FSPC_BIT_ERR] = 1'b1; // Set beats a software clear
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) ctrl_q <= `FSPC_CTRL_RST;
		else ctrl_q <= ctrl_d;
	end

	// Address pair, software owned
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			addrLo_q <= 8'h00;
			addrHi_q <= 6'h00;
		end else if (apbWr) begin
			if (hitAddrLo) addrLo_q <= pwdata[7:0];
			if (hitAddrHi) addrHi_q <= pwdata[5:0];
		end
	end

	// Data pair; a read capture beats a software write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dataLo_q <= 8'h00;
			dataHi_q <= 6'h00;
		end else if (rdDone) begin
			{dataHi_q, dataLo_q} <= flashRdData; // RQ3
		end else if (apbWr) begin
			if (hitDataLo) dataLo_q <= pwdata[7:0];
			if (hitDataHi) dataHi_q <= pwdata[5:0];
		end
	end

	// Unlock tracker: 55h then AAh, consumed by any go attempt
	always_ff @(posedge clk or posedge rst) begin
		if (rst) unlk_q <= `FSPC_UNLK_NONE;
		else if (goReq) unlk_q <= `FSPC_UNLK_NONE; // RQ20
		else if (apbWr & hitUnlock) begin
			if (pwdata[7:0] == `FSPC_KEY1) unlk_q <= `FSPC_UNLK_HALF;
			else if (pwdata[7:0] == `FSPC_KEY2 && unlk_q == `FSPC_UNLK_HALF)
				unlk_q <= `FSPC_UNLK_FULL;
			else unlk_q <= `FSPC_UNLK_NONE;
		end
	end

	// Operation captured at go so later bit changes cannot redirect it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			opAddr_q <= 14'h0000;
			opErase_q <= 1'b0;
			opLatch_q <= 1'b0;
		end else if (goAccept) begin
			opAddr_q <= fullAddr;
			opErase_q <= ctrl_q[`FSPC_BIT_FREE];
			opLatch_q <= ctrl_q[`FSPC_BIT_LATCH_ONLY];
		end
	end

	// Sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			S_IDLE: begin
				if (goAccept) state_d = S_GO_ALIGN;
				else if (rdAccept) state_d = S_RD_ALIGN;
			end
			S_RD_ALIGN: if (cycEn) state_d = S_RD_PASS;
			S_RD_PASS: if (cycEn) state_d = S_RD_DO;
			S_RD_DO: if (cycEn) state_d = S_IDLE;
			S_GO_ALIGN: if (cycEn) state_d = S_SETUP1;
			S_SETUP1: if (cycEn) state_d = S_SETUP2;
			S_SETUP2: begin
				if (cycEn) begin
					if (opErase_q) state_d = S_BUSY;
					else if (opLatch_q) state_d = S_IDLE; // RQ17
					else state_d = S_PROG;
				end
			end
			S_PROG: if (progLast) state_d = S_BUSY;
			S_BUSY: if (timerDone) state_d = S_IDLE; // RQ12
			default: state_d = S_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) state_q <= S_IDLE;
		else state_q <= state_d;
	end

	// Core control: squash one fetch on read, two on setup
	assign cpuSquash = (state_q == S_RD_DO) | (state_q == S_SETUP1) | (state_q == S_SETUP2); // RQ2 RQ10
	// Only the array phases stall the core
	assign cpuHalt = (state_q == S_PROG) | (state_q == S_BUSY); // RQ11 RQ19

	// Walks all eight latches, one array word per clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) progCnt_q <= 4'h0;
		else if (state_q == S_PROG && !progLast) progCnt_q <= progCnt_q + 4'h1;
		else progCnt_q <= 4'h0;
	end

	// Array requests; programming never pairs with an erase
	always_comb begin
		flashReqD = '0;
		if (state_d == S_RD_DO) begin
			flashReqD.rd = 1'b1;
			flashReqD.addr = fullAddr;
		end
		if (setupEnd & opErase_q) begin
			flashReqD.erase = 1'b1; // RQ13
			flashReqD.addr = opAddr_q & `FSPC_ROW_MASK; // RQ6
		end
		if (state_q == S_PROG && progCnt_q != 4'h0) begin
			flashReqD.prog = 1'b1;
			flashReqD.addr = {opAddr_q[13:3], 3'(progCnt_q - 4'h1)}; // RQ7 RQ14
			flashReqD.wdata = latchRd;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) flashReq_q <= '0;
		else flashReq_q <= flashReqD;
	end
	assign flashReq = flashReq_q;

	fspc_latch_mem #(.DEPTH(`FSPC_LATCHES), .W(14)) u_latch (
		.clk(clk),
		.rst(rst),
		.we(latchWe),
		.waddr(opAddr_q[2:0]), // RQ24
		.wdata({dataHi_q, dataLo_q}), // RQ22
		.setAll(opDone & ~opErase_q), // RQ15
		.raddr(progCnt_q[2:0]),
		.rdata(latchRd)
	);

	fspc_timer #(.INSTR_CLKS(INSTR_CLKS), .CNT_W(CNT_W)) u_timer (
		.clk(clk),
		.rst(rst),
		.start(timerStart),
		.loadVal(CELL_LOAD),
		.cycEn(cycEn),
		.done(timerDone)
	);

	// Checks
	sequence s_read_slot;
		(state_q == S_RD_PASS) && cycEn;
	endsequence
	sequence s_go_end;
		(state_q == S_GO_ALIGN) && cycEn;
	endsequence

	property p_rd_squash;
		@(posedge clk) disable iff (rst) s_read_slot |=> cpuSquash && flashReq_q.rd;
	endproperty
	a_rd_squash: assert property (p_rd_squash) else $error("read slot not squashed"); // RQ2

	property p_rd_data;
		@(posedge clk) disable iff (rst)
		(state_q == S_RD_DO) && cycEn |=> {dataHi_q, dataLo_q} == $past(flashRdData);
	endproperty
	a_rd_data: assert property (p_rd_data) else $error("read word not captured"); // RQ3

	property p_setup_two;
		@(posedge clk) disable iff (rst) s_go_end |=> cpuSquash[*8];
	endproperty
	a_setup_two: assert property (p_setup_two) else $error("setup not two cycles"); // RQ10

	property p_free_clear;
		@(posedge clk) disable iff (rst)
		opDone && opErase_q |=> !ctrl_q[`FSPC_BIT_FREE] && !ctrl_q[`FSPC_BIT_WR];
	endproperty
	a_free_clear: assert property (p_free_clear) else $error("erase bit not cleared"); // RQ9

	property p_row_align;
		@(posedge clk) disable iff (rst) flashReq_q.erase |-> flashReq_q.addr[4:0] == 5'h00;
	endproperty
	a_row_align: assert property (p_row_align) else $error("erase not row aligned"); // RQ6

	property p_block_bound;
		@(posedge clk) disable iff (rst)
		flashReq_q.prog |-> flashReq_q.addr[13:3] == opAddr_q[13:3] && !flashReq_q.erase;
	endproperty
	a_block_bound: assert property (p_block_bound) else $error("write left its block"); // RQ14

	property p_latch_no_stall;
		@(posedge clk) disable iff (rst)
		setupEnd && opLatch_q && !opErase_q |=> isIdle && !cpuHalt;
	endproperty
	a_latch_no_stall: assert property (p_latch_no_stall) else $error("latch load stalled"); // RQ17

	property p_protect;
		@(posedge clk) disable iff (rst)
		flashReq_q.erase || flashReq_q.prog |-> !isProtected(flashReq_q.addr, protectRegion);
	endproperty
	a_protect: assert property (p_protect) else $error("protected word touched"); // RQ23

	property p_prog_eight;
		@(posedge clk) disable iff (rst)
		$rose(flashReq_q.prog) |-> flashReq_q.prog[*8] ##1 !flashReq_q.prog;
	endproperty
	a_prog_eight: assert property (p_prog_eight) else $error("block not eight words"); // RQ7

	property p_resume;
		@(posedge clk) disable iff (rst) $fell(cpuHalt) |-> isIdle && !cpuSquash;
	endproperty
	a_resume: assert property (p_resume) else $error("resume not clean"); // RQ12

	// Refusals leave the sequencer idle; only a refused go sets the error bit
	property p_go_refuse;
		@(posedge clk) disable iff (rst)
		goRefuse |=> isIdle && ctrl_q[`FSPC_BIT_ERR] && !ctrl_q[`FSPC_BIT_WR];
	endproperty
	a_go_refuse: assert property (p_go_refuse) else $error("refused go not flagged"); // RQ20

	property p_rd_refuse;
		@(posedge clk) disable iff (rst) rdRefuse |=> isIdle && !ctrl_q[`FSPC_BIT_RD];
	endproperty
	a_rd_refuse: assert property (p_rd_refuse) else $error("refused read not dropped"); // RQ1
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
`include "fspc_consts.svh"

module tb_top
	import fspc_pkg::*;
	;
	localparam int CELL = 50;
	localparam logic [11:0] ALO = `FSPC_OFF_ADDR_LO;
	localparam logic [11:0] AHI = `FSPC_OFF_ADDR_HI;
	localparam logic [11:0] DLO = `FSPC_OFF_DATA_LO;
	localparam logic [11:0] DHI = `FSPC_OFF_DATA_HI;
	localparam logic [11:0] CTRL = `FSPC_OFF_CTRL;
	localparam logic [11:0] UNLK = `FSPC_OFF_UNLOCK;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, cpuSquash, cpuHalt, e;
	logic haltSeen, eraseSeen, rdSeen;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv, seed;
	logic [1:0] protectRegion;
	logic [13:0] flashRdData, a, base;
	logic [13:0] expW [8];
	fspc_flash_req_t flashReq;
	int errTotal, samplesChecked, cycles, n, i, k, h;

	fspc_top #(.CELL_CYCLES(CELL), .INSTR_CLKS(4)) u_fspc_top (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .protectRegion(protectRegion), .flashRdData(flashRdData),
		.flashReq(flashReq), .cpuSquash(cpuSquash), .cpuHalt(cpuHalt)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Sticky monitors, sampled mid-cycle where outputs are settled
	always @(negedge clk) begin
		if (cpuHalt === 1'b1) haltSeen = 1'b1;
		if (flashReq.erase === 1'b1) eraseSeen = 1'b1;
		if (flashReq.rd === 1'b1) rdSeen = 1'b1;
	end

	// Hang guard: generous against the several hundred cycles expected
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errTotal++;
			closeOut();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			errTotal++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic closeOut();
		$display("checked %0d mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// One APB transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d,
			output logic [31:0] r, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] ad, input logic [31:0] d);
		logic [31:0] r;
		logic err;
		apb(1'b1, ad, d, r, err);
	endtask

	task automatic rdReg(input logic [11:0] ad);
		apb(1'b0, ad, 32'h0, rv, e);
	endtask

	task automatic setPair(input logic [11:0] lo, input logic [13:0] v);
		wr(lo, {24'h0, v[7:0]});
		wr(lo + 12'h004, {26'h0, v[13:8]});
	endtask

	// Poll until neither start bit is pending
	task automatic waitIdle();
		for (n = 0; n < 300; n++) begin
			rdReg(CTRL);
			if (rv[1:0] === 2'b00) break;
		end
	endtask

	task automatic waitFor(input int w);
		for (n = 0; n < 3000; n++) begin
			@(negedge clk);
			if (w == 0 && flashReq.rd === 1'b1) break;
			if (w == 1 && cpuSquash === 1'b1) break;
			if (w == 2 && flashReq.prog === 1'b1) break;
		end
	endtask

	task automatic unlockGo(input logic [7:0] c);
		wr(UNLK, 32'h55);
		wr(UNLK, 32'haa);
		wr(CTRL, {24'h0, c | 8'h02});
	endtask

	// Go with unlock, then measure the squashed setup slots
	task automatic goSquash(input logic [7:0] c);
		unlockGo(c);
		waitFor(1);
		k = 0;
		while (cpuSquash === 1'b1 && k < 20) begin
			k++;
			@(negedge clk);
		end
		check("setup squash clocks", k, 8);
	endtask

	task automatic haltLen();
		h = 0;
		while (cpuHalt === 1'b1 && h < 400) begin
			h++;
			@(negedge clk);
		end
	endtask

	// Eight ascending program pulses inside one latch block, then halt
	task automatic progCheck();
		waitFor(2);
		check("halt at program", cpuHalt, 1);
		for (k = 0; k < 8; k++) begin
			check("prog pulse", flashReq.prog, 1);
			check("prog addr", flashReq.addr, base | 14'(k));
			check("prog data", flashReq.wdata, expW[k]);
			@(negedge clk);
		end
		check("no ninth pulse", flashReq.prog, 0);
		haltLen();
		// Ten halted clocks already passed: eight program pulses and two lead-in slots
		check("write halt length", h + 10, CELL + 9);
		waitIdle();
		check("no erase on write", eraseSeen, 0);
	endtask

	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		protectRegion = 2'h3;
		flashRdData = 14'h0000;
		seed = 32'hde478a72;
		haltSeen = 1'b0;
		eraseSeen = 1'b0;
		rdSeen = 1'b0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// Reset values, write-only key, unmapped place
		rdReg(ALO);
		check("addr low reset", rv, 0);
		rdReg(CTRL);
		check("ctrl reset", rv, 0);
		wr(UNLK, 32'h55);
		rdReg(UNLK);
		check("unlock reads zero", rv, 0);
		wr(UNLK, 32'h00);
		apb(1'b0, 12'h018, 32'h0, rv, e);
		check("unmapped error", e, 1);
		// Reads: squashed slot, data pair loaded and then held
		for (i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			a = seed[13:0];
			setPair(ALO, a);
			seed = lfsr(seed);
			flashRdData <= seed[13:0];
			wr(CTRL, 32'h41);
			waitFor(0);
			check("read addr", flashReq.addr, a);
			k = 0;
			while (flashReq.rd === 1'b1 && k < 10) begin
				check("read squash", cpuSquash, 1);
				k++;
				@(negedge clk);
			end
			check("read slot clocks", k, 4);
			waitIdle();
			flashRdData <= ~seed[13:0];
			rdReg(DLO);
			check("data low", rv, {24'h0, seed[7:0]});
			rdReg(DHI);
			check("data high", rv, {26'h0, seed[13:8]});
			rdReg(DLO);
			check("data held", rv, {24'h0, seed[7:0]});
		end
		// Read with configuration space selected just drops the start bit
		rdSeen = 1'b0;
		wr(CTRL, 32'h61);
		waitIdle();
		rdReg(CTRL);
		check("config read refused", rv, 32'h60);
		check("no refused read slot", rdSeen, 0);
		// Missing unlock is refused
		haltSeen = 1'b0;
		setPair(ALO, 14'h2345);
		wr(CTRL, 32'h4e);
		waitIdle();
		rdReg(CTRL);
		check("no unlock refused", rv, 32'hcc);
		wr(CTRL, 32'h4c);
		// Protected destinations at each limit are refused
		for (i = 0; i < 3; i++) begin
			protectRegion <= 2'(i);
			a = (i == 0) ? 14'h3f00 : (i == 1) ? 14'h1fe0 : 14'h01e0;
			setPair(ALO, a);
			unlockGo(8'h4c);
			waitIdle();
			rdReg(CTRL);
			check("protected refused", rv, 32'hcc);
			wr(CTRL, 32'h4c);
		end
		check("no halt on refusal", haltSeen, 0);
		// Row erase at a random address above the low protected area
		seed = lfsr(seed);
		a = seed[13:0] | 14'h0200;
		setPair(ALO, a);
		goSquash(8'h4c);
		check("erase pulse", flashReq.erase, 1);
		check("erase row addr", flashReq.addr, a & 14'h3fe0);
		check("erase halt", cpuHalt, 1);
		haltLen();
		check("erase halt length", (h >= CELL) && (h <= CELL + 2), 1);
		waitIdle();
		rdReg(CTRL);
		check("erase select cleared", rv, 32'h44);
		protectRegion <= 2'h3;
		// Block write, latch 3 left unloaded
		seed = lfsr(seed);
		base = seed[13:0] & 14'h3ff8;
		for (i = 0; i < 8; i++) expW[i] = 14'h3fff;
		wr(CTRL, 32'h54);
		haltSeen = 1'b0;
		eraseSeen = 1'b0;
		for (i = 0; i < 7; i++) begin
			if (i != 3) begin
				seed = lfsr(seed);
				expW[i] = seed[13:0];
				setPair(ALO, base | 14'(i));
				setPair(DLO, expW[i]);
				goSquash(8'h54);
				waitIdle();
			end
		end
		check("latch load no stall", haltSeen, 0);
		seed = lfsr(seed);
		expW[7] = seed[13:0];
		setPair(ALO, base | 14'h7);
		setPair(DLO, expW[7]);
		goSquash(8'h44);
		progCheck();
		// Next block: only latch 5 loaded, others back to erased value
		base = base ^ 14'h0008;
		for (i = 0; i < 8; i++) expW[i] = 14'h3fff;
		seed = lfsr(seed);
		expW[5] = seed[13:0];
		setPair(ALO, base | 14'h5);
		setPair(DLO, expW[5]);
		goSquash(8'h44);
		progCheck();
		closeOut();
	end
endmodule
